// ==== logic/usfa_pkg.sv ====
package usfa_pkg;
  // --------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h40;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h44;
  localparam logic [7:0] OFF_FRAME_INFO = 8'h48;
  localparam logic [7:0] OFF_FUNCTION_ADDR = 8'h4c;
  localparam logic [7:0] OFF_DESCRIPTOR_BASE = 8'h50;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [15:0] CONTROL_RST = 16'h0003;
  localparam logic [15:0] FUNCTION_ADDR_RST = 16'h0000;
  localparam logic [15:0] DESCRIPTOR_BASE_RST = 16'h0000;

  // --------------------------------------------------------------
  // control fields
  // --------------------------------------------------------------
  localparam int CTL_MASK_LSB = 8;
  localparam int CTL_SUSPEND_FORCE = 3;
  localparam int CTL_LOW_POWER = 2;
  localparam int CTL_POWER_DOWN = 1;
  localparam int CTL_FORCE_RESET = 0;

  // --------------------------------------------------------------
  // irq status fields (event index = bit - EVT_LSB)
  // --------------------------------------------------------------
  localparam int IST_CTR = 15;
  localparam int EVT_LSB = 8;
  localparam int EVT_W = 7;
  localparam int EVT_MEM_OVR = 6;
  localparam int EVT_ERR = 5;
  localparam int EVT_RESUME = 4;
  localparam int EVT_IDLE_IDLE_SUSPEND_FLAG = 3;
  localparam int EVT_BUS_RESET = 2;
  localparam int EVT_SOF = 1;
  localparam int EVT_MISSED = 0;
  localparam int IST_DIR = 4;

  // --------------------------------------------------------------
  // frame info and address fields
  // --------------------------------------------------------------
  localparam int FI_PLUS = 15;
  localparam int FI_MINUS = 14;
  localparam int FI_LOCK = 13;
  localparam int FI_LOST_LSB = 11;
  localparam int FA_ENABLE = 7;
  localparam int DB_LSB = 3;
  localparam int DESC_ENTRY_SHIFT = 3;
  localparam int LOCK_SOF_COUNT = 2;
  localparam int MISSED_RUN_IDLE_SUSPEND_FLAG = 3;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int IDLE_TIME_MS = 3;
  localparam int FRAME_TIME_MS = 1;
  localparam int IDLE_CYC = IDLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FRAME_CYC = FRAME_TIME_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// ==== logic/usfa_core.sv ====
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
// Behaviour
// - four fault kinds raise the error flag
// - event flags clear only on written zero
// - wake activity: flag, drop low power, notify
// - 3 ms without traffic sets idle suspend
// - suspend check armed after reset, off while forced
// - bus reset sets flag, resets protocol engine
// - no transfers until reset flag cleared
// - bus reset clears address, endpoints and frame lock
// - frame packet sets flag, updates frame number
// - timer flags missed frame every 1 ms gap
// - three missed frames without traffic: suspend
// - missed frame flagged even before lock
// - direction bit: 0 in only, 1 otherwise
// - pending index: priority set, then lowest register
// - frame info shows both line levels
// - lock after two frames, cleared by reset/suspend
// - lost count increments, cleared by frame packet
// - frame number from latest frame packet
// - function disabled: no transactions at all
// - token needs address and endpoint match
// - descriptor base bits 15:3, low bits zero
// - matching token fetches descriptor entry
// - any masked event raises one shared irq
module usfa_core
  import usfa_pkg::*;
#(
  parameter int NUM_EP = 8,
  parameter int IDLE_CYCLES = usfa_pkg::IDLE_CYC,
  parameter int FRAME_CYCLES = usfa_pkg::FRAME_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic bus_reset,
  input wire logic bus_activity,
  input wire logic sof_in,
  input wire logic [10:0] sof_frame,
  input wire logic host_timeout,
  input wire logic crc_fault,
  input wire logic stuffing_fault,
  input wire logic framing_fault,
  input wire logic mem_overrun,
  input wire logic line_plus_state,
  input wire logic line_minus_state,
  input wire logic token_valid,
  input wire logic [6:0] token_addr,
  input wire logic [3:0] token_ep,
  input wire logic [NUM_EP-1:0] in_done_flag,
  input wire logic [NUM_EP-1:0] out_done_flag,
  input wire logic [NUM_EP-1:0] ep_priority_set,
  input wire logic [NUM_EP*4-1:0] endpoint_number_field,
  output logic irq,
  output logic resume_notify_line,
  output logic low_power_request,
  output logic suspend_force,
  output logic proto_reset,
  output logic ep_regs_reset,
  output logic xfer_enable,
  output logic desc_fetch_req,
  output logic [15:0] desc_fetch_addr,
  output logic [3:0] token_slot
);
  import usfa_pkg::*;

  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam int FW = $clog2(FRAME_CYCLES + 1);

  if (NUM_EP < 1 || NUM_EP > 16) begin : g_bad_ep
    $error("NUM_EP must be 1..16");
  end
  if (IDLE_CYCLES < 2 || FRAME_CYCLES < 2) begin : g_bad_cyc
    $error("cycle counts must be at least 2");
  end

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic req;
  logic wr_go;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [15:0] wdat;

  assign req = read | write;
  assign wr_go = write & ~waitrequest;
  assign wdat = writedata[15:0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ctl_mask, next_ctl_mask;
  logic next_suspend_force, next_low_power_request;
  logic power_down, next_power_down;
  logic force_reset, next_force_reset;
  logic [EVT_W-1:0] evt, next_evt;
  logic dir, next_dir;
  logic [3:0] pending_endpoint_index, next_pending_endpoint_index;
  logic [10:0] frame_number, next_frame_number;
  logic [1:0] lost, next_lost;
  logic lock, next_lock;
  logic [1:0] sof_seen, next_sof_seen;
  logic [1:0] missed_run, next_missed_run;
  logic [IW-1:0] idle_cnt, next_idle_cnt;
  logic [FW-1:0] frame_cnt, next_frame_cnt;
  logic armed, next_armed;
  logic force_prev, next_force_prev;
  logic rst_prev, next_rst_prev;
  logic [6:0] dev_addr, next_dev_addr;
  logic fen, next_fen;
  logic [12:0] base, next_base;
  logic next_irq, next_resume_notify_line, next_proto_reset, next_ep_regs_reset;
  logic next_xfer_enable, next_desc_fetch_req;
  logic [15:0] next_desc_fetch_addr;
  logic [3:0] next_token_slot;

  // ----------------------------------------------------------------
  // per endpoint terms
  // ----------------------------------------------------------------
  logic [NUM_EP-1:0] req_hi, req_lo, ep_match;
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    assign req_hi[i] = (in_done_flag[i] | out_done_flag[i]) & ep_priority_set[i];
    assign req_lo[i] = (in_done_flag[i] | out_done_flag[i]) & ~ep_priority_set[i];
    assign ep_match[i] = endpoint_number_field[i*4 +: 4] == token_ep;
  end

  // ----------------------------------------------------------------
  // combinational events
  // ----------------------------------------------------------------
  logic rst_active, reset_evt, missed_evt, idle_hit, wake_evt, token_hit;
  logic [EVT_W-1:0] ev_set, ev_clr;
  logic [3:0] pick, slot;
  logic pick_dir;

  assign rst_active = bus_reset | force_reset;
  assign reset_evt = rst_active & ~rst_prev;
  assign missed_evt = ~suspend_force & ~sof_in & ~rst_active
                      & (frame_cnt == FW'(FRAME_CYCLES - 1));
  assign wake_evt = suspend_force & bus_activity;
  assign idle_hit = armed & ~bus_activity & ~sof_in
                    & ((idle_cnt == IW'(IDLE_CYCLES - 1))
                    | (missed_evt & (missed_run == 2'(MISSED_RUN_IDLE_SUSPEND_FLAG - 1))));
  assign token_hit = token_valid & fen & xfer_enable & (token_addr == dev_addr)
                     & (|ep_match);

  always_comb begin
    pick = 4'h0;
    pick_dir = 1'b0;
    slot = 4'h0;
    for (int i = NUM_EP - 1; i >= 0; i--) begin
      if (req_lo[i]) begin
        pick = 4'(i);
        pick_dir = out_done_flag[i];
      end
    end
    for (int i = NUM_EP - 1; i >= 0; i--) begin
      if (req_hi[i]) begin
        pick = 4'(i);
        pick_dir = out_done_flag[i];
      end
    end
    for (int i = NUM_EP - 1; i >= 0; i--) begin
      if (ep_match[i]) begin
        slot = 4'(i);
      end
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[EVT_MEM_OVR] = mem_overrun;
    ev_set[EVT_ERR] = host_timeout | crc_fault | stuffing_fault | framing_fault;
    ev_set[EVT_RESUME] = wake_evt;
    ev_set[EVT_IDLE_IDLE_SUSPEND_FLAG] = idle_hit;
    ev_set[EVT_BUS_RESET] = reset_evt;
    ev_set[EVT_SOF] = sof_in;
    ev_set[EVT_MISSED] = missed_evt;
    ev_clr = '0;
    if (wr_go && address == OFF_IRQ_STATUS && byteenable[1]) begin
      ev_clr = ~wdat[EVT_LSB +: EVT_W];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_waitrequest = ~(req & waitrequest);
    next_readdata = readdata;
    if (req && waitrequest) begin
      next_readdata = '0;
      case (address)
        OFF_CONTROL: begin
          next_readdata[15:0] = {ctl_mask, 4'h0, suspend_force, low_power_request,
                                 power_down, force_reset};
        end
        OFF_IRQ_STATUS: begin
          next_readdata[15:0] = {|(in_done_flag | out_done_flag), evt, 3'h0, dir, pending_endpoint_index};
        end
        OFF_FRAME_INFO: begin
          next_readdata[15:0] = {line_plus_state, line_minus_state, lock, lost,
                                 frame_number};
        end
        OFF_FUNCTION_ADDR: begin
          next_readdata[15:0] = {8'h00, fen, dev_addr};
        end
        OFF_DESCRIPTOR_BASE: begin
          next_readdata[15:0] = {base, 3'h0};
        end
        default: begin
          next_readdata = '0;
        end
      endcase
    end

    next_ctl_mask = ctl_mask;
    next_suspend_force = suspend_force;
    next_low_power_request = low_power_request;
    next_power_down = power_down;
    next_force_reset = force_reset;
    next_dev_addr = dev_addr;
    next_fen = fen;
    next_base = base;
    if (wr_go && address == OFF_CONTROL) begin
      if (byteenable[1]) begin
        next_ctl_mask = wdat[CTL_MASK_LSB +: 8];
      end
      if (byteenable[0]) begin
        next_suspend_force = wdat[CTL_SUSPEND_FORCE];
        next_low_power_request = wdat[CTL_LOW_POWER];
        next_power_down = wdat[CTL_POWER_DOWN];
        next_force_reset = wdat[CTL_FORCE_RESET];
      end
    end
    if (wr_go && address == OFF_FUNCTION_ADDR && byteenable[0]) begin
      next_fen = wdat[FA_ENABLE];
      next_dev_addr = wdat[6:0];
    end
    if (wr_go && address == OFF_DESCRIPTOR_BASE) begin
      if (byteenable[1]) begin
        next_base[12:5] = wdat[15:8];
      end
      if (byteenable[0]) begin
        next_base[4:0] = wdat[7:DB_LSB];
      end
    end
    if (wake_evt) begin
      next_low_power_request = 1'b0;
    end
    if (reset_evt) begin
      next_fen = 1'b0;
      next_dev_addr = 7'h00;
    end

    next_evt = (evt & ~ev_clr) | ev_set;
    next_dir = pick_dir;
    next_pending_endpoint_index = pick;

    next_rst_prev = rst_active;
    next_force_prev = suspend_force;
    next_proto_reset = rst_active;
    next_ep_regs_reset = reset_evt;

    next_armed = armed;
    if (reset_evt) begin
      next_armed = 1'b1;
    end else if (suspend_force) begin
      next_armed = 1'b0;
    end else if (force_prev) begin
      next_armed = 1'b1;
    end

    next_resume_notify_line = resume_notify_line;
    if (wake_evt) begin
      next_resume_notify_line = 1'b1;
    end else if (!suspend_force) begin
      next_resume_notify_line = 1'b0;
    end

    next_idle_cnt = idle_cnt;
    if (bus_activity || sof_in || rst_active || !armed) begin
      next_idle_cnt = '0;
    end else if (idle_cnt != IW'(IDLE_CYCLES)) begin
      next_idle_cnt = idle_cnt + IW'(1);
    end

    next_frame_cnt = frame_cnt + FW'(1);
    if (sof_in || rst_active || suspend_force || missed_evt) begin
      next_frame_cnt = '0;
    end

    next_missed_run = missed_run;
    if (bus_activity || sof_in || rst_active) begin
      next_missed_run = 2'h0;
    end else if (missed_evt && missed_run != 2'h3) begin
      next_missed_run = missed_run + 2'h1;
    end

    next_lost = lost;
    if (sof_in) begin
      next_lost = 2'h0;
    end else if (missed_evt && lost != 2'h3) begin
      next_lost = lost + 2'h1;
    end

    next_frame_number = sof_in ? sof_frame : frame_number;

    next_sof_seen = sof_seen;
    next_lock = lock;
    if (rst_active || suspend_force || idle_hit || wake_evt) begin
      next_sof_seen = 2'h0;
      next_lock = 1'b0;
    end else if (sof_in) begin
      if (sof_seen != 2'(LOCK_SOF_COUNT)) begin
        next_sof_seen = sof_seen + 2'h1;
      end
      if (sof_seen == 2'(LOCK_SOF_COUNT - 1)) begin
        next_lock = 1'b1;
      end
    end else if (missed_evt) begin
      next_sof_seen = lock ? sof_seen : 2'h0;
    end

    next_xfer_enable = ~next_evt[EVT_BUS_RESET] & ~rst_active & ~power_down;
    next_irq = |(next_evt & next_ctl_mask[EVT_W-1:0])
               | (next_ctl_mask[7] & |(in_done_flag | out_done_flag));

    next_desc_fetch_req = token_hit;
    next_token_slot = token_hit ? slot : token_slot;
    next_desc_fetch_addr = desc_fetch_addr;
    if (token_hit) begin
      next_desc_fetch_addr = {base, 3'h0} + {9'h000, slot, 3'h0};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= '0;
      waitrequest <= 1'b1;
      ctl_mask <= CONTROL_RST[15:8];
      suspend_force <= CONTROL_RST[CTL_SUSPEND_FORCE];
      low_power_request <= CONTROL_RST[CTL_LOW_POWER];
      power_down <= CONTROL_RST[CTL_POWER_DOWN];
      force_reset <= CONTROL_RST[CTL_FORCE_RESET];
      evt <= '0;
      dir <= 1'b0;
      pending_endpoint_index <= 4'h0;
      frame_number <= 11'h000;
      lost <= 2'h0;
      lock <= 1'b0;
      sof_seen <= 2'h0;
      missed_run <= 2'h0;
      idle_cnt <= '0;
      frame_cnt <= '0;
      armed <= 1'b1;
      force_prev <= 1'b0;
      rst_prev <= 1'b0;
      dev_addr <= FUNCTION_ADDR_RST[6:0];
      fen <= FUNCTION_ADDR_RST[FA_ENABLE];
      base <= DESCRIPTOR_BASE_RST[15:3];
      irq <= 1'b0;
      resume_notify_line <= 1'b0;
      proto_reset <= 1'b0;
      ep_regs_reset <= 1'b0;
      xfer_enable <= 1'b0;
      desc_fetch_req <= 1'b0;
      desc_fetch_addr <= 16'h0000;
      token_slot <= 4'h0;
    end else begin
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      ctl_mask <= next_ctl_mask;
      suspend_force <= next_suspend_force;
      low_power_request <= next_low_power_request;
      power_down <= next_power_down;
      force_reset <= next_force_reset;
      evt <= next_evt;
      dir <= next_dir;
      pending_endpoint_index <= next_pending_endpoint_index;
      frame_number <= next_frame_number;
      lost <= next_lost;
      lock <= next_lock;
      sof_seen <= next_sof_seen;
      missed_run <= next_missed_run;
      idle_cnt <= next_idle_cnt;
      frame_cnt <= next_frame_cnt;
      armed <= next_armed;
      force_prev <= next_force_prev;
      rst_prev <= next_rst_prev;
      dev_addr <= next_dev_addr;
      fen <= next_fen;
      base <= next_base;
      irq <= next_irq;
      resume_notify_line <= next_resume_notify_line;
      proto_reset <= next_proto_reset;
      ep_regs_reset <= next_ep_regs_reset;
      xfer_enable <= next_xfer_enable;
      desc_fetch_req <= next_desc_fetch_req;
      desc_fetch_addr <= next_desc_fetch_addr;
      token_slot <= next_token_slot;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wake_cause;
    suspend_force && bus_activity;
  endsequence
  sequence s_wake_effect;
    evt[EVT_RESUME] && !low_power_request && resume_notify_line;
  endsequence

  chk_err_flag_set: assert property (@(posedge clk) disable iff (!rstn)
    (host_timeout || crc_fault || stuffing_fault || framing_fault) |=> evt[EVT_ERR])
    else $error("error flag not raised");
  chk_zero_clears: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && address == OFF_IRQ_STATUS && byteenable[1] && !wdat[EVT_LSB + EVT_SOF]
     && !sof_in) |=> !evt[EVT_SOF])
    else $error("written zero did not clear flag");
  chk_one_keeps: assert property (@(posedge clk) disable iff (!rstn)
    (wr_go && address == OFF_IRQ_STATUS && wdat[EVT_LSB + EVT_ERR] && !evt[EVT_ERR]
     && !ev_set[EVT_ERR]) |=> !evt[EVT_ERR])
    else $error("written one changed flag");
  chk_wake_steps: assert property (@(posedge clk) disable iff (!rstn)
    s_wake_cause |=> s_wake_effect)
    else $error("wake sequence incomplete");
  chk_reset_flag: assert property (@(posedge clk) disable iff (!rstn)
    reset_evt |=> evt[EVT_BUS_RESET] && ep_regs_reset && proto_reset && dev_addr == 7'h00)
    else $error("bus reset not handled");
  chk_xfer_block: assert property (@(posedge clk) disable iff (!rstn)
    evt[EVT_BUS_RESET] |-> !xfer_enable)
    else $error("transfers enabled during reset flag");
  chk_sof_frame: assert property (@(posedge clk) disable iff (!rstn)
    sof_in |=> evt[EVT_SOF] && frame_number == $past(sof_frame) && lost == 2'h0)
    else $error("frame packet not recorded");
  chk_lost_count: assert property (@(posedge clk) disable iff (!rstn)
    (missed_evt && lost != 2'h3) |=> lost == $past(lost) + 2'h1 && evt[EVT_MISSED])
    else $error("lost count not advanced");
  chk_fetch_enable: assert property (@(posedge clk) disable iff (!rstn)
    desc_fetch_req |-> $past(fen) && $past(token_addr) == $past(dev_addr))
    else $error("fetch without enabled matching function");
  chk_irq_shared: assert property (@(posedge clk) disable iff (!rstn)
    (|(evt & ctl_mask[EVT_W-1:0])) |-> irq)
    else $error("masked event without irq");
endmodule

// ==== test/usfa_host_model.sv ====
`timescale 1ns/100ps
module usfa_host_model (
  input wire logic clk,
  output logic bus_reset,
  output logic bus_activity,
  output logic sof_in,
  output logic [10:0] sof_frame,
  output logic [3:0] faults,
  output logic line_plus_state,
  output logic line_minus_state,
  output logic token_valid,
  output logic [6:0] token_addr,
  output logic [3:0] token_ep
);
  initial begin
    {bus_reset, bus_activity, sof_in, token_valid, line_minus_state, faults} = '0;
    {sof_frame, token_addr, token_ep} = '0;
    line_plus_state = 1'b1;
  end
  task automatic send_sof(input logic [10:0] fn);
    @(posedge clk);
    sof_in <= 1'b1;
    sof_frame <= fn;
    @(posedge clk);
    sof_in <= 1'b0;
    sof_frame <= ~fn;
  endtask
  task automatic send_token(input logic [6:0] a, input logic [3:0] ep);
    @(posedge clk);
    token_valid <= 1'b1;
    token_addr <= a;
    token_ep <= ep;
    @(posedge clk);
    token_valid <= 1'b0;
    token_addr <= ~a;
    token_ep <= ~ep;
  endtask
  task automatic drive_reset(input int cyc);
    @(posedge clk);
    bus_reset <= 1'b1;
    line_plus_state <= 1'b0;
    repeat (cyc) @(posedge clk);
    bus_reset <= 1'b0;
    line_plus_state <= 1'b1;
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    if (k < 4) begin
      faults[k] <= 1'b1;
    end else begin
      bus_activity <= 1'b1;
      {line_plus_state, line_minus_state} <= 2'b01;
    end
    @(posedge clk);
    faults <= 4'h0;
    bus_activity <= 1'b0;
  endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import usfa_pkg::*;
  typedef struct packed {logic [7:0] a; logic w; logic [15:0] d, m, e;} usfa_row_t;
  logic clk, rstn, read, write, waitrequest, irq, resume_notify_line, low_power_request;
  logic suspend_force, proto_reset, ep_regs_reset, xfer_enable, desc_fetch_req, bus_reset;
  logic bus_activity, sof_in, line_plus_state, line_minus_state, token_valid, mem_ovr;
  logic [7:0] address, in_done_flag, out_done_flag, ep_priority_set;
  logic [31:0] writedata, readdata, q, endpoint_number_field;
  logic [3:0] byteenable, faults, token_ep, token_slot;
  logic [10:0] sof_frame;
  logic [6:0] token_addr;
  logic [15:0] desc_fetch_addr, last_addr;
  int error_cnt, checked, n, n0, fetch_cnt, ep_rst_cnt;
  usfa_row_t rows [16] = '{{8'h40, 1'b0, 16'h0, 16'hffff, 16'h0003},
    {8'h4c, 1'b0, 16'h0, 16'hffff, 16'h0}, {8'h50, 1'b0, 16'h0, 16'hffff, 16'h0},
    {8'h44, 1'b0, 16'h0, 16'h0400, 16'h0400}, {8'h44, 1'b1, 16'hffff, 16'h0, 16'h0},
    {8'h44, 1'b0, 16'h0, 16'h0400, 16'h0400}, {8'h40, 1'b1, 16'h0, 16'h0, 16'h0},
    {8'h44, 1'b1, 16'h0, 16'h0, 16'h0}, {8'h44, 1'b0, 16'h0, 16'h0400, 16'h0},
    {8'h4c, 1'b1, 16'h00a5, 16'h0, 16'h0}, {8'h4c, 1'b0, 16'h0, 16'hffff, 16'h00a5},
    {8'h50, 1'b1, 16'hffff, 16'h0, 16'h0}, {8'h50, 1'b0, 16'h0, 16'hffff, 16'hfff8},
    {8'h48, 1'b0, 16'h0, 16'hc000, 16'h8000}, {8'h60, 1'b1, 16'h1234, 16'h0, 16'h0},
    {8'h60, 1'b0, 16'h0, 16'hffff, 16'h0}};
  usfa_core #(.NUM_EP(8), .IDLE_CYCLES(40), .FRAME_CYCLES(10)) dut (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .bus_reset(bus_reset), .bus_activity(bus_activity),
    .sof_in(sof_in), .sof_frame(sof_frame), .host_timeout(faults[0]), .crc_fault(faults[1]),
    .stuffing_fault(faults[2]), .framing_fault(faults[3]), .mem_overrun(mem_ovr),
    .line_plus_state(line_plus_state), .line_minus_state(line_minus_state),
    .token_valid(token_valid), .token_addr(token_addr), .token_ep(token_ep),
    .in_done_flag(in_done_flag), .out_done_flag(out_done_flag),
    .ep_priority_set(ep_priority_set), .endpoint_number_field(endpoint_number_field),
    .irq(irq), .resume_notify_line(resume_notify_line), .low_power_request(low_power_request),
    .suspend_force(suspend_force), .proto_reset(proto_reset), .ep_regs_reset(ep_regs_reset),
    .xfer_enable(xfer_enable), .desc_fetch_req(desc_fetch_req),
    .desc_fetch_addr(desc_fetch_addr), .token_slot(token_slot));
  usfa_host_model host (.clk(clk), .bus_reset(bus_reset), .bus_activity(bus_activity),
    .sof_in(sof_in), .sof_frame(sof_frame), .faults(faults),
    .line_plus_state(line_plus_state), .line_minus_state(line_minus_state),
    .token_valid(token_valid), .token_addr(token_addr), .token_ep(token_ep));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (desc_fetch_req === 1'b1) begin
      fetch_cnt++;
      last_addr = desc_fetch_addr;
    end
    if (ep_regs_reset === 1'b1) ep_rst_cnt++;
  end
  // ----
  // bus tasks
  // ----
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge clk);
    address <= a;
    read <= ~w;
    write <= w;
    writedata <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    if (n >= 20) begin
      error_cnt++;
      finish_test();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] m, e, input string nm);
    bus(a, 1'b0, 16'h0000);
    `CHK(nm, e, q[15:0] & m)
    $display("test %s done", nm);
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  // ----
  // main sequence
  // ----
  initial begin
    {rstn, read, write, address, writedata, in_done_flag, out_done_flag, ep_priority_set} = '0;
    mem_ovr = 1'b0;
    byteenable = 4'hf;
    endpoint_number_field = 32'h76543210;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) `CHK("row", rows[i].e, q[15:0] & rows[i].m)
    end
    $display("test rows done");
    host.drive_reset(5);
    host.send_sof(11'h123);
    host.send_sof(11'h124);
    rc(OFF_FRAME_INFO, 16'h3fff, 16'h2124, "lock");
    rc(OFF_IRQ_STATUS, 16'h0600, 16'h0600, "rst_sof");
    `CHK("xfer_off", 1'b0, xfer_enable)
    `CHK("ep_rst", 2, ep_rst_cnt)
    rc(OFF_FUNCTION_ADDR, 16'hffff, 16'h0000, "addr_clr");
    rc(OFF_DESCRIPTOR_BASE, 16'hffff, 16'hfff8, "base_kept");
    bus(OFF_IRQ_STATUS, 1'b1, 16'h0000);
    repeat (3) @(posedge clk);
    `CHK("xfer_on", 1'b1, xfer_enable)
    host.send_sof(11'h001);
    repeat (33) @(posedge clk);
    rc(OFF_FRAME_INFO, 16'h3800, 16'h1800, "lost3");
    rc(OFF_IRQ_STATUS, 16'h0900, 16'h0900, "miss_idle_suspend_flag");
    bus(OFF_IRQ_STATUS, 1'b1, 16'h0000);
    repeat (15) @(posedge clk);
    rc(OFF_IRQ_STATUS, 16'h0100, 16'h0100, "miss_unlock");
    bus(OFF_CONTROL, 1'b1, 16'h0200);
    bus(OFF_IRQ_STATUS, 1'b1, 16'h0000);
    host.send_sof(11'h002);
    repeat (2) @(posedge clk);
    `CHK("irq_on", 1'b1, irq)
    bus(OFF_IRQ_STATUS, 1'b1, 16'h0000);
    repeat (2) @(posedge clk);
    `CHK("irq_off", 1'b0, irq)
    for (int k = 0; k < 4; k++) begin
      bus(OFF_IRQ_STATUS, 1'b1, 16'h0000);
      host.pulse(k);
      rc(OFF_IRQ_STATUS, 16'h2000, 16'h2000, "err");
    end
    bus(OFF_IRQ_STATUS, 1'b1, 16'h0000);
    mem_ovr <= 1'b1;
    @(posedge clk);
    mem_ovr <= 1'b0;
    rc(OFF_IRQ_STATUS, 16'h4000, 16'h4000, "ovr");
    in_done_flag <= 8'h12;
    ep_priority_set <= 8'h10;
    rc(OFF_IRQ_STATUS, 16'h801f, 16'h8004, "pend_in");
    out_done_flag <= 8'h10;
    rc(OFF_IRQ_STATUS, 16'h801f, 16'h8014, "pend_both");
    ep_priority_set <= 8'h00;
    rc(OFF_IRQ_STATUS, 16'h801f, 16'h8001, "pend_low");
    bus(OFF_FUNCTION_ADDR, 1'b1, 16'h0085);
    bus(OFF_DESCRIPTOR_BASE, 1'b1, 16'h0040);
    byteenable <= 4'h2;
    bus(OFF_FUNCTION_ADDR, 1'b1, 16'h0000);
    byteenable <= 4'hf;
    n0 = fetch_cnt;
    host.send_token(7'h05, 4'h2);
    repeat (3) @(posedge clk);
    `CHK("fetch", n0 + 1, fetch_cnt)
    `CHK("fetch_addr", 16'h0050, last_addr)
    `CHK("slot", 4'h2, token_slot)
    host.send_token(7'h06, 4'h2);
    endpoint_number_field <= 32'h76549210;
    host.send_token(7'h05, 4'h9);
    repeat (3) @(posedge clk);
    `CHK("fetch9", n0 + 2, fetch_cnt)
    `CHK("fetch9_addr", 16'h0058, last_addr)
    `CHK("slot9", 4'h3, token_slot)
    host.send_token(7'h05, 4'h3);
    bus(OFF_FUNCTION_ADDR, 1'b1, 16'h0005);
    host.send_token(7'h05, 4'h2);
    repeat (3) @(posedge clk);
    `CHK("no_fetch", n0 + 2, fetch_cnt)
    bus(OFF_CONTROL, 1'b1, 16'h000c);
    bus(OFF_IRQ_STATUS, 1'b1, 16'h0000);
    `CHK("lp_set", 1'b1, low_power_request)
    `CHK("sf_set", 1'b1, suspend_force)
    repeat (50) @(posedge clk);
    rc(OFF_IRQ_STATUS, 16'h0900, 16'h0000, "forced");
    host.pulse(4);
    repeat (2) @(posedge clk);
    `CHK("lp_clr", 1'b0, low_power_request)
    `CHK("notify", 1'b1, resume_notify_line)
    rc(OFF_IRQ_STATUS, 16'h1000, 16'h1000, "wake");
    rc(OFF_FRAME_INFO, 16'hc000, 16'h4000, "lines");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rc(OFF_IRQ_STATUS, 16'h1400, 16'h0400, "rst_again");
    `CHK("proto", 1'b1, proto_reset)
    finish_test();
  end
endmodule
